/* design/bst_tap.sv */
`timescale 1ns/10ps
`include "bst_params.svh"

module bst_tap #(
   parameter int DR_W = `BST_DR_W
) (
   // system clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // test port, clocked by its own clock
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output bst_pkg::bst_pin_s tdo_out,
   // normal-function terminals
   input wire logic [DR_W-1:0] func_in,
   output logic [DR_W-1:0] func_out,
   // status in system clock domain
   output bst_pkg::bst_status_s status_out,
   output logic upd_pulse_out
);

   // ==========================================
   // tap state machine
   bst_pkg::bst_state_e state_reg;
   bst_pkg::bst_state_e state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bst_pkg::ST_RESET: state_next = tms_in ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE: state_next = tms_in ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: state_next = tms_in ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: state_next = tms_in ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_SHIFT_DR: state_next = tms_in ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_EXIT1_DR: state_next = tms_in ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_PAUSE_DR: state_next = tms_in ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
         bst_pkg::ST_EXIT2_DR: state_next = tms_in ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
         bst_pkg::ST_UPD_DR: state_next = tms_in ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: state_next = tms_in ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: state_next = tms_in ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_SHIFT_IR: state_next = tms_in ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_EXIT1_IR: state_next = tms_in ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_PAUSE_IR: state_next = tms_in ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
         bst_pkg::ST_EXIT2_IR: state_next = tms_in ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
         bst_pkg::ST_UPD_IR: state_next = tms_in ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         default: state_next = bst_pkg::ST_RESET;
      endcase
   end

   // mode select needs no synchroniser: it is launched on the falling edge
   always_ff @(posedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= bst_pkg::ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   sequence s_in_pause_dr;
      state_reg == bst_pkg::ST_PAUSE_DR;
   endsequence

   sequence s_in_exit2_dr;
      state_reg == bst_pkg::ST_EXIT2_DR;
   endsequence

   a_idle_hold: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_IDLE && !tms_in |=> state_reg == bst_pkg::ST_IDLE)
      else $error("idle state not held");

   a_cap_ir_to_shift: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_CAP_IR && !tms_in |=> state_reg == bst_pkg::ST_SHIFT_IR)
      else $error("capture-ir did not enter shift");

   a_exit1_to_pause: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_EXIT1_DR && !tms_in |=> s_in_pause_dr)
      else $error("exit1 did not enter pause");

   a_pause_to_exit2: assert property (@(posedge tck_in) disable iff (rst_in)
      s_in_pause_dr ##0 tms_in |=> s_in_exit2_dr)
      else $error("pause did not leave for exit2");

   a_exit2_to_update: assert property (@(posedge tck_in) disable iff (rst_in)
      s_in_exit2_dr ##0 tms_in |=> state_reg == bst_pkg::ST_UPD_DR)
      else $error("exit2 did not leave for update");

   a_update_to_idle: assert property (@(posedge tck_in) disable iff (rst_in)
      (state_reg == bst_pkg::ST_UPD_IR || state_reg == bst_pkg::ST_UPD_DR) && !tms_in |=>
         state_reg == bst_pkg::ST_IDLE)
      else $error("update did not return to idle");

   a_sel_ir_to_reset: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SEL_IR && tms_in |=> state_reg == bst_pkg::ST_RESET)
      else $error("select-ir did not leave for reset");

   // ==========================================
   // instruction register
   logic [`BST_IR_W-1:0] ir_sh_reg;
   logic [`BST_IR_W-1:0] ir_reg;
   logic bypass_sel;

   assign bypass_sel = (ir_reg == `BST_IR_BYPASS);

   always_ff @(posedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         ir_sh_reg <= `BST_IR_CAPTURE;
      end else if (state_reg == bst_pkg::ST_CAP_IR) begin
         ir_sh_reg <= `BST_IR_CAPTURE;
      end else if (state_reg == bst_pkg::ST_SHIFT_IR) begin
         ir_sh_reg <= {tdi_in, ir_sh_reg[`BST_IR_W-1:1]};
      end
   end

   a_ir_tdo_bit: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SHIFT_IR |-> tdo_out.data == ir_sh_reg[0])
      else $error("serial output does not show the instruction bit");

   // held in the active register until update, so shifting never disturbs it
   always_ff @(negedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         ir_reg <= `BST_IR_RESET;
      end else if (state_reg == bst_pkg::ST_RESET) begin
         ir_reg <= `BST_IR_RESET;
      end else if (state_reg == bst_pkg::ST_UPD_IR) begin
         ir_reg <= ir_sh_reg;
      end
   end

   a_ir_update_val: assert property (@(negedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_UPD_IR |=> ir_reg == $past(ir_sh_reg))
      else $error("instruction not taken from the shift stage");

   // ==========================================
   // data registers: bypass and function register
   logic byp_reg;
   logic [DR_W-1:0] dr_sh_reg;
   logic [DR_W-1:0] func_meta_reg;
   logic [DR_W-1:0] func_sync_reg;

   // function pins arrive from outside the test clock domain: two stages
   // first, so a new pin level must stand two test clocks before capture
   always_ff @(posedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         func_meta_reg <= DR_W'(`BST_DR_RESET);
         func_sync_reg <= DR_W'(`BST_DR_RESET);
      end else begin
         func_meta_reg <= func_in;
         func_sync_reg <= func_meta_reg;
      end
   end

   always_ff @(posedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         byp_reg <= 1'b0;
      end else if (state_reg == bst_pkg::ST_CAP_DR) begin
         byp_reg <= 1'b0;
      end else if (state_reg == bst_pkg::ST_SHIFT_DR) begin
         byp_reg <= tdi_in;
      end
   end

   always_ff @(posedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         dr_sh_reg <= DR_W'(`BST_DR_RESET);
      end else if (!bypass_sel && state_reg == bst_pkg::ST_CAP_DR) begin
         dr_sh_reg <= func_sync_reg;
      end else if (!bypass_sel && state_reg == bst_pkg::ST_SHIFT_DR) begin
         dr_sh_reg <= {tdi_in, dr_sh_reg[DR_W-1:1]};
      end
   end

   a_func_capture: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_CAP_DR && !bypass_sel |=> dr_sh_reg == $past(func_sync_reg))
      else $error("function inputs not captured");

   a_bypass_no_capture: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_CAP_DR && bypass_sel |=> $stable(dr_sh_reg))
      else $error("function register captured in bypass");

   a_dr_tdo_bit: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SHIFT_DR && !bypass_sel |-> tdo_out.data == dr_sh_reg[0])
      else $error("serial output does not show the data bit");

   always_ff @(negedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         func_out <= DR_W'(`BST_DR_RESET);
      end else if (!bypass_sel && state_reg == bst_pkg::ST_UPD_DR) begin
         func_out <= dr_sh_reg;
      end
   end

   a_func_update_val: assert property (@(negedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_UPD_DR && !bypass_sel |=> func_out == $past(dr_sh_reg))
      else $error("function outputs not updated");

   a_bypass_no_update: assert property (@(negedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_UPD_DR && bypass_sel |=> $stable(func_out))
      else $error("function outputs updated in bypass");

   // ==========================================
   // serial output on falling edge
   always_ff @(negedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         tdo_out <= '0;
      end else begin
         tdo_out.en <= (state_reg == bst_pkg::ST_SHIFT_IR) ||
            (state_reg == bst_pkg::ST_SHIFT_DR);
         if (state_reg == bst_pkg::ST_SHIFT_IR) begin
            tdo_out.data <= ir_sh_reg[0];
         end else if (state_reg == bst_pkg::ST_SHIFT_DR) begin
            tdo_out.data <= bypass_sel ? byp_reg : dr_sh_reg[0];
         end
      end
   end

   a_tdo_idle_off: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_IDLE || state_reg == bst_pkg::ST_RESET |-> !tdo_out.en)
      else $error("serial output enabled outside shift");

   // ==========================================
   // update event crossing into system clock
   // toggle rather than pulse: test clock may stop right after update
   logic upd_tgl_reg;
   logic [2:0] upd_sync_reg;

   always_ff @(negedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         upd_tgl_reg <= 1'b0;
      end else if (state_reg == bst_pkg::ST_UPD_IR || state_reg == bst_pkg::ST_RESET) begin
         upd_tgl_reg <= ~upd_tgl_reg;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         upd_sync_reg <= 3'h0;
      end else begin
         upd_sync_reg <= {upd_sync_reg[1:0], upd_tgl_reg};
      end
   end

   // instruction is stable for many system cycles after the toggle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_out <= '{instr: `BST_IR_RESET, bypass: 1'b1};
         upd_pulse_out <= 1'b0;
      end else begin
         upd_pulse_out <= upd_sync_reg[2] ^ upd_sync_reg[1];
         if (upd_sync_reg[2] ^ upd_sync_reg[1]) begin
            status_out.instr <= ir_reg;
            status_out.bypass <= bypass_sel;
         end
      end
   end

   a_status_pulse_one: assert property (@(posedge clk_in) disable iff (rst_in)
      upd_pulse_out |=> !upd_pulse_out)
      else $error("status pulse longer than one cycle");

   a_status_copy: assert property (@(posedge clk_in) disable iff (rst_in)
      upd_pulse_out |-> status_out.instr == $past(ir_reg))
      else $error("status does not hold the active instruction");

   a_status_bypass: assert property (@(posedge clk_in) disable iff (rst_in)
      upd_pulse_out |-> status_out.bypass == (status_out.instr == `BST_IR_BYPASS))
      else $error("status bypass flag wrong");

   // ==========================================
   // checks
   sequence s_enter_exit1_ir;
      state_reg == bst_pkg::ST_EXIT1_IR;
   endsequence

   sequence s_last_bit_in;
      ir_sh_reg[`BST_IR_W-1] == $past(tdi_in);
   endsequence

   a_reset_to_idle: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_RESET && !tms_in |=> state_reg == bst_pkg::ST_IDLE)
      else $error("reset state did not move to idle");

   a_ir_capture_val: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_CAP_IR |=> ir_sh_reg == 8'h81)
      else $error("capture value wrong");

   a_ir_shift_bit: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SHIFT_IR && !tms_in |=>
         ir_sh_reg == {$past(tdi_in), $past(ir_sh_reg[7:1])})
      else $error("instruction shift wrong");

   a_ir_last_bit: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SHIFT_IR && tms_in |=> s_enter_exit1_ir ##0 s_last_bit_in)
      else $error("last instruction bit lost");

   a_tdo_on_shift: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SHIFT_IR || state_reg == bst_pkg::ST_SHIFT_DR |-> tdo_out.en)
      else $error("serial output not enabled in shift");

   a_tdo_off_exit: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_EXIT1_IR || state_reg == bst_pkg::ST_EXIT1_DR |-> !tdo_out.en)
      else $error("serial output still enabled in exit1");

   a_ir_update_time: assert property (@(negedge tck_in) disable iff (rst_in)
      $changed(ir_reg) |-> $past(state_reg) == bst_pkg::ST_UPD_IR ||
         $past(state_reg) == bst_pkg::ST_RESET)
      else $error("instruction changed outside update");

   a_bypass_capture: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_CAP_DR |=> !byp_reg)
      else $error("bypass did not capture zero");

   a_bypass_delay: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_SHIFT_DR && bypass_sel |=>
         byp_reg == $past(tdi_in) ##0 (!tdo_out.en || tdo_out.data == byp_reg))
      else $error("bypass stage wrong");

   a_dr_update_time: assert property (@(negedge tck_in) disable iff (rst_in)
      $changed(func_out) |-> $past(state_reg) == bst_pkg::ST_UPD_DR)
      else $error("function output changed outside update");

   a_pause_hold: assert property (@(posedge tck_in) disable iff (rst_in)
      state_reg == bst_pkg::ST_PAUSE_DR && !tms_in |=> state_reg == bst_pkg::ST_PAUSE_DR)
      else $error("pause state not held");

endmodule : bst_tap

/* shared/bst_params.svh */
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// ==========================================
// instruction register
`define BST_IR_W 8
`define BST_IR_CAPTURE 8'h81
`define BST_IR_BYPASS 8'hFF
`define BST_IR_RESET 8'hFF

// ==========================================
// data register
`define BST_DR_W 8
`define BST_DR_RESET 8'h00

`endif

/* shared/bst_pkg.sv */
package bst_pkg;

   // ==========================================
   // tap controller states
   typedef enum logic [3:0] {
      ST_RESET = 4'b0000,
      ST_IDLE = 4'b0001,
      ST_SEL_DR = 4'b0010,
      ST_CAP_DR = 4'b0011,
      ST_SHIFT_DR = 4'b0100,
      ST_EXIT1_DR = 4'b0101,
      ST_PAUSE_DR = 4'b0110,
      ST_EXIT2_DR = 4'b0111,
      ST_UPD_DR = 4'b1000,
      ST_SEL_IR = 4'b1001,
      ST_CAP_IR = 4'b1010,
      ST_SHIFT_IR = 4'b1011,
      ST_EXIT1_IR = 4'b1100,
      ST_PAUSE_IR = 4'b1101,
      ST_EXIT2_IR = 4'b1110,
      ST_UPD_IR = 4'b1111
   } bst_state_e;

   // ==========================================
   // three-state serial pin
   typedef struct packed {
      logic data;
      logic en;
   } bst_pin_s;

   // ==========================================
   // instruction status seen by system clock
   typedef struct packed {
      logic [7:0] instr;
      logic bypass;
   } bst_status_s;

endpackage : bst_pkg

/* test/boundary_scan_tap_timing_test.sv */
`timescale 1ns/10ps
module boundary_scan_tap_timing_test;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic tck_in;
   logic tms_in;
   logic tdi_in;
   logic [7:0] func_in = 8'h00;
   logic [7:0] func_out;
   bst_pkg::bst_pin_s tdo_out;
   bst_pkg::bst_status_s status_out;
   logic upd_pulse_out;
   logic tdo_q[$];
   bst_pkg::bst_status_s stat_q[$];
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   integer seed = 32'hF473D202;
   logic [31:0] r;

   always #10 clk_in = ~clk_in;

   bst_tap #(.DR_W(8)) bst_tap_inst (.clk_in(clk_in), .rst_in(rst_in), .tck_in(tck_in),
      .tms_in(tms_in), .tdi_in(tdi_in), .tdo_out(tdo_out), .func_in(func_in),
      .func_out(func_out), .status_out(status_out), .upd_pulse_out(upd_pulse_out));
   bst_ctl_model bst_ctl_model_inst (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in));

   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   task automatic step(input logic tms);
      bst_ctl_model_inst.step(tms, 1'b0, 1'b0);
   endtask : step

   // bit 0 shows at the fall entering shift, so notes go in first
   task automatic shift(input int n, input logic [7:0] d, input logic [7:0] q);
      for (int i = 0; i < n; i++) begin
         tdo_q.push_back(q[i]);
      end
      step(1'b0);
      for (int i = 0; i < n; i++) begin
         bst_ctl_model_inst.step(i == n - 1, d[i], 1'b1);
      end
   endtask : shift

   task automatic ir_scan(input logic [7:0] v);
      step(1'b1);
      step(1'b1);
      step(1'b0);
      shift(8, v, 8'h81);
      stat_q.push_back({v, v == 8'hFF});
      step(1'b1);
      step(1'b0);
   endtask : ir_scan

   task automatic dr_scan(input int n, input logic [7:0] d, input logic [7:0] q, input logic p);
      step(1'b1);
      step(1'b0);
      shift(n, d, q);
      if (p) begin
         step(1'b0);
         step(1'b0);
         step(1'b1);
      end
      step(1'b1);
      step(1'b0);
   endtask : dr_scan

   // ==========================================
   // watchers
   always @(negedge tck_in) begin
      #2;
      if (tdo_out.en === 1'b1) begin
         if (tdo_q.size() == 0) begin
            check(9'h001, 9'h000, "tdo driven outside shift");
         end else begin
            check(tdo_out.data, tdo_q.pop_front(), "tdo bit");
         end
      end
   end

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end else if (upd_pulse_out === 1'b1) begin
         if (stat_q.size() == 0) begin
            check(9'h001, 9'h000, "stray status update");
         end else begin
            check(status_out, stat_q.pop_front(), "status");
         end
      end
   end

   // ==========================================
   // main sequence
   initial begin
      bst_ctl_model_inst.step(1'b1, 1'b0, 1'b0);
      @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      check(status_out, 9'h1FF, "reset status");
      check({1'b0, func_out}, 9'h000, "reset func");
      check({7'h00, tdo_out}, 9'h000, "reset tdo");
      step(1'b0);
      step(1'b0);
      r = $random(seed);
      r[7] = 1'b0;
      ir_scan(r[7:0]);
      @(posedge clk_in);
      func_in <= r[23:16];
      @(posedge clk_in);
      dr_scan(8, r[15:8], r[23:16], 1'b1);
      check({1'b0, func_out}, {1'b0, r[15:8]}, "func update");
      ir_scan(8'hFF);
      dr_scan(3, 8'h05, 8'h02, 1'b0);
      check({1'b0, func_out}, {1'b0, r[15:8]}, "bypass held func");
      step(1'b1);
      step(1'b1);
      stat_q.push_back(9'h1FF);
      step(1'b1);
      repeat (12) @(posedge clk_in);
      check(9'(tdo_q.size()), 9'h000, "tdo bits missing");
      check(9'(stat_q.size()), 9'h000, "status updates missing");
      print_verdict();
   end
endmodule : boundary_scan_tap_timing_test

/* test/bst_ctl_model.sv */
`timescale 1ns/10ps
// ==========================================
// test controller: 64 ns test clock, at rest low between frames
module bst_ctl_model (
   // test port drive
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out
);
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end

   // unused data line flips so a stale level never passes for data
   task automatic step(input logic tms, input logic tdi, input logic use_tdi);
      tms_out = tms;
      tdi_out = use_tdi ? tdi : ~tdi_out;
      #32 tck_out = 1'b1;
      #32 tck_out = 1'b0;
   endtask : step
endmodule : bst_ctl_model
